// ===== src/dab_pkg.sv
// shared constants and carriers of the diagnostic result and bypass block
package dab_pkg;

    // register indices; byte address on the bus is index * 4
    localparam logic [5:0] DAB_IDX_INPUT1_RESULT = 6'h25;
    localparam logic [5:0] DAB_IDX_TEMPERATURE_RESULT = 6'h26;
    localparam logic [5:0] DAB_IDX_DIAG_MUX_RESULT = 6'h27;
    localparam logic [5:0] DAB_IDX_COMPARATOR_OFFSET = 6'h28;
    localparam logic [5:0] DAB_IDX_APPLIED_DAC_CODE = 6'h2c;
    localparam logic [5:0] DAB_IDX_RAW_CONVERSION_RESULT = 6'h2d;
    localparam logic [5:0] DAB_IDX_CONVERSION_OVERRIDE = 6'h2e;

    // field layout of conversion_override
    localparam int DAB_BYP_DATA_EN_BIT = 15;
    localparam int DAB_BYP_OFFSET_EN_BIT = 14;
    localparam int DAB_BYP_GND_DIS_BIT = 13;
    localparam int DAB_BYP_DATA_MSB = 11;

    // widths and reset values
    localparam int DAB_ADC_W = 12;
    localparam int DAB_DAC_W = 16;
    localparam int DAB_REG_W = 16;
    localparam logic [11:0] DAB_ADC_RESET = 12'h000;
    localparam logic [15:0] DAB_DAC_RESET = 16'h0000;
    localparam logic [11:0] DAB_ADC_MAX = 12'hfff;

    // channel being converted
    typedef enum logic [1:0] {
        DAB_CH_INPUT0 = 2'b00,
        DAB_CH_INPUT1 = 2'b01,
        DAB_CH_TEMP   = 2'b10,
        DAB_CH_DIAG   = 2'b11
    } dab_chan_e;

    typedef struct packed {
        logic        data_en;
        logic        offset_en;
        logic        gnd_dis;
        logic [11:0] data;
    } dab_byp_s;

    typedef struct packed {
        logic        valid;
        dab_chan_e   chan;
        logic [11:0] data;
    } dab_conv_s;

endpackage : dab_pkg

// ===== src/dab_apb_slave.sv
// apb slave front end: decode, error answer and registered read data
`timescale 1ns/1ps
`default_nettype none
module dab_apb_slave
    import dab_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // register file side
    output logic      [5:0]  reg_idx,
    output logic             wr_stb,
    input  wire logic [15:0] rd_word
);

    typedef struct packed {
        logic [15:0] rdata;
        logic        err;
    } dab_apb_s;

    dab_apb_s q;
    dab_apb_s d;
    logic     hit;

    assign reg_idx = paddr[7:2];

    always_comb begin
        case (reg_idx)
            DAB_IDX_INPUT1_RESULT, DAB_IDX_TEMPERATURE_RESULT,
            DAB_IDX_DIAG_MUX_RESULT, DAB_IDX_COMPARATOR_OFFSET,
            DAB_IDX_APPLIED_DAC_CODE, DAB_IDX_RAW_CONVERSION_RESULT,
            DAB_IDX_CONVERSION_OVERRIDE: hit = (paddr[1:0] == 2'h0);
            default: hit = 1'b0;
        endcase
    end

    // read data is captured in the setup cycle so the access phase needs no wait
    always_comb begin
        d = q;
        if (psel && !penable) begin
            d.rdata = hit ? rd_word : 16'h0000;
            d.err   = !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && q.err;
    assign prdata  = {16'h0000, q.rdata};
    assign wr_stb  = psel && penable && pwrite && !q.err;

endmodule : dab_apb_slave
`default_nettype wire

// ===== src/dab_conv_proc.sv
// per-conversion path: offset choice, correction and data substitution
`timescale 1ns/1ps
`default_nettype none
module dab_conv_proc
    import dab_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // conversion in
    input  wire logic        conv_valid,
    input  wire dab_chan_e   conv_chan,
    input  wire logic [11:0] conv_raw,
    input  wire logic [11:0] meas_offset,
    input  wire dab_byp_s    byp,
    // processed result
    output dab_conv_s        result,
    output logic      [11:0] offset_used
);

    typedef struct packed {
        dab_conv_s   res;
        logic [11:0] off;
    } dab_proc_s;

    dab_proc_s   q;
    dab_proc_s   d;
    logic [11:0] off_sel;
    logic [13:0] diff;

    // data override wins over offset override when both are set
    assign off_sel = (byp.offset_en && !byp.data_en) ? byp.data : meas_offset; // R5 R10
    // offset is signed two's complement; raw is unsigned
    assign diff = {2'b00, conv_raw} - {{2{off_sel[11]}}, off_sel}; // R11

    always_comb begin
        d           = q;
        d.res.valid = 1'b0;
        d.off       = off_sel;
        if (conv_valid) begin
            d.res.valid = 1'b1;
            d.res.chan  = conv_chan;
            if (byp.data_en) begin
                d.res.data = byp.data; // R8 R9
            end else if (diff[13]) begin
                d.res.data = DAB_ADC_RESET;
            end else if (diff[12]) begin
                d.res.data = DAB_ADC_MAX;
            end else begin
                d.res.data = diff[11:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign result      = q.res;
    assign offset_used = q.off;

endmodule : dab_conv_proc
`default_nettype wire

// ===== src/dab_top.sv
// diagnostic converter result readback and override register block
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - second analog input result held as 12 bits, upper four bits read zero
// R2 - latest die temperature result held as 12 bits, resets to zero
// R3 - self-diagnostic mux result held as 12 bits, read only
// R4 - measured comparator offset readable as 12 bits
// R5 - offset override uses bypass data, readback still shows measured offset
// R6 - applied dac code readable as 16 bits, may lag target while slewing
// R7 - raw result of each conversion, uncorrected and never substituted
// R8 - data override substitutes bypass data and ignores offset; off at reset
// R9 - under data override bypass value lands in channel readback and limits
// R10 - data override takes priority when both overrides are set
// R11 - under offset override bypass data is a signed two's complement offset
// R12 - ground sampling disable bit stops ground sampling; zero keeps it on
module dab_top
    import dab_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb register bus
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // converter sequencer
    input  wire logic        conv_valid,
    input  wire dab_chan_e   conv_chan,
    input  wire logic [11:0] conv_raw,
    input  wire logic        offset_valid,
    input  wire logic [11:0] meas_offset,
    // dac datapath
    input  wire logic [15:0] dac_code,
    // analog control and fault evaluation
    output logic             ground_sampling_disable,
    output logic      [11:0] applied_offset,
    output logic             result_valid,
    output dab_chan_e        result_chan,
    output logic      [11:0] result_data
);

    typedef struct packed {
        logic [11:0] input1;
        logic [11:0] temp;
        logic [11:0] diag;
        logic [11:0] offset;
        logic [15:0] dac;
        logic [11:0] raw;
        dab_byp_s    byp;
    } dab_top_s;

    dab_top_s    q;
    dab_top_s    d;

    logic [5:0]  reg_idx;
    logic        wr_stb;
    logic [15:0] rd_word;
    dab_conv_s   conv_res;
    logic [11:0] offset_used;

    dab_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .reg_idx (reg_idx),
        .wr_stb  (wr_stb),
        .rd_word (rd_word)
    );

    // the bypass fields are sampled with the conversion, so a write landing
    // in the same cycle as conv_valid takes effect on the next conversion
    dab_conv_proc u_proc (
        .pclk        (pclk),
        .presetn     (presetn),
        .conv_valid  (conv_valid),
        .conv_chan   (conv_chan),
        .conv_raw    (conv_raw),
        .meas_offset (q.offset),
        .byp         (q.byp),
        .result      (conv_res),
        .offset_used (offset_used)
    );

    // read multiplexer; bits above the field width read as zero
    always_comb begin
        rd_word = 16'h0000;
        case (reg_idx)
            DAB_IDX_INPUT1_RESULT: begin
                rd_word = {4'h0, q.input1}; // R1
            end
            DAB_IDX_TEMPERATURE_RESULT: begin
                rd_word = {4'h0, q.temp}; // R2
            end
            DAB_IDX_DIAG_MUX_RESULT: begin
                rd_word = {4'h0, q.diag}; // R3
            end
            DAB_IDX_COMPARATOR_OFFSET: begin
                rd_word = {4'h0, q.offset}; // R4 R5
            end
            DAB_IDX_APPLIED_DAC_CODE: begin
                rd_word = q.dac; // R6
            end
            DAB_IDX_RAW_CONVERSION_RESULT: begin
                rd_word = {4'h0, q.raw}; // R7
            end
            DAB_IDX_CONVERSION_OVERRIDE: begin
                rd_word[DAB_BYP_DATA_EN_BIT]     = q.byp.data_en;
                rd_word[DAB_BYP_OFFSET_EN_BIT]   = q.byp.offset_en;
                rd_word[DAB_BYP_GND_DIS_BIT]     = q.byp.gnd_dis;
                rd_word[DAB_BYP_DATA_MSB:0]      = q.byp.data;
            end
            default: begin
                rd_word = 16'h0000;
            end
        endcase
    end

    always_comb begin
        d = q;

        // applied code follows the slewing datapath every cycle
        d.dac = dac_code; // R6

        // measured offset is never touched by the override register
        if (offset_valid) begin
            d.offset = meas_offset; // R4 R5
        end

        // raw word bypasses both correction and substitution
        if (conv_valid) begin
            d.raw = conv_raw; // R7
        end

        // processed input1, temperature and diag results land in their own channel readback; input0 results are not stored
        if (conv_res.valid) begin
            case (conv_res.chan)
                DAB_CH_INPUT1: begin
                    d.input1 = conv_res.data; // R1 R9
                end
                DAB_CH_TEMP: begin
                    d.temp = conv_res.data; // R2 R9
                end
                DAB_CH_DIAG: begin
                    d.diag = conv_res.data; // R3 R9
                end
                default: begin
                    d.input1 = q.input1;
                end
            endcase
        end

        // only the documented writable fields store; bit 12 stays zero
        if (wr_stb && reg_idx == DAB_IDX_CONVERSION_OVERRIDE) begin
            d.byp.data_en   = pwdata[DAB_BYP_DATA_EN_BIT]; // R8
            d.byp.offset_en = pwdata[DAB_BYP_OFFSET_EN_BIT]; // R11
            d.byp.gnd_dis   = pwdata[DAB_BYP_GND_DIS_BIT]; // R12
            d.byp.data      = pwdata[DAB_BYP_DATA_MSB:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.input1 <= DAB_ADC_RESET;
            q.temp   <= DAB_ADC_RESET;
            q.diag   <= DAB_ADC_RESET;
            q.offset <= DAB_ADC_RESET;
            q.dac    <= DAB_DAC_RESET;
            q.raw    <= DAB_ADC_RESET;
            q.byp    <= '0; // R8 R12
        end else begin
            q <= d;
        end
    end

    // outputs toward the analog side and the fault limit checker
    assign ground_sampling_disable = q.byp.gnd_dis; // R12
    assign applied_offset          = offset_used; // R5 R10
    assign result_valid            = conv_res.valid; // R9
    assign result_chan             = conv_res.chan;
    assign result_data             = conv_res.data; // R8 R9

endmodule : dab_top
`default_nettype wire

// ===== test/dab_top_checker.sv
// port assertions of the override block
`timescale 1ns/1ps
`default_nettype none
module dab_top_checker
    import dab_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // conversion
    input wire logic        conv_valid,
    input wire dab_chan_e   conv_chan,
    input wire logic        ground_sampling_disable,
    input wire logic        result_valid,
    input wire dab_chan_e   result_chan,
    input wire logic [11:0] result_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] byp_q;
    logic        acc;
    logic        hit;
    assign acc = psel && penable;
    assign hit = paddr inside {8'h94, 8'h98, 8'h9c, 8'ha0, 8'hb0, 8'hb4, 8'hb8};
    // shadow of the override register, rebuilt from bus writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            byp_q <= 16'h0000;
        else if (acc && pwrite && paddr == 8'hb8)
            byp_q <= pwdata[15:0];
    end
    chk_err_unmapped: assert property (acc && !hit |-> pslverr) else $error("no error on unmapped");
    chk_err_mapped: assert property (acc && hit |-> !pslverr) else $error("error on mapped");
    chk_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0000) else $error("upper read bits");
    chk_result_pulse: assert property (conv_valid |=> result_valid) else $error("no result pulse");
    chk_no_result: assert property (!conv_valid |=> !result_valid) else $error("stray result");
    chk_result_chan: assert property (conv_valid |=> result_chan == $past(conv_chan))
        else $error("result channel");
    chk_data_subst: assert property (conv_valid && byp_q[15] |=> result_data == $past(byp_q[11:0]))
        else $error("bypass data not used");
    chk_gnd_level: assert property (ground_sampling_disable == byp_q[13]) else $error("ground bit");
    chk_result_hold: assert property (!conv_valid |=> $stable(result_data)) else $error("result moved");
endmodule : dab_top_checker
bind dab_top dab_top_checker chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pslverr, .conv_valid, .conv_chan, .ground_sampling_disable, .result_valid, .result_chan, .result_data);
`default_nettype wire

// ===== test/test_dab_top.sv
// self-checking bench of the override block
`timescale 1ns/1ps
`default_nettype none
module test_dab_top
    import dab_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, conv_valid, offset_valid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic [11:0] conv_raw, meas_offset, applied_offset, result_data;
    logic [15:0] dac_code;
    logic        pready, pslverr, ground_sampling_disable, result_valid, e;
    dab_chan_e   conv_chan, result_chan;
    int          fail_count, comparisons, cycles;
    logic [7:0]  addrs [7] = '{8'h94, 8'h98, 8'h9c, 8'ha0, 8'hb0, 8'hb4, 8'hb8};

    dab_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .conv_valid, .conv_chan, .conv_raw, .offset_valid, .meas_offset, .dac_code,
        .ground_sampling_disable, .applied_offset, .result_valid, .result_chan, .result_data);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // hang guard; the whole run needs about a hundred cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic check(string n, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask : check

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(string n, logic [7:0] a, logic [15:0] exp);
        apb(1'b0, a, 32'h0);
        check(n, {16'h0000, exp}, d);
        check("pslverr", 32'h0, e);
    endtask : rd

    task automatic conv(dab_chan_e c, logic [11:0] raw, logic [11:0] exp);
        @(posedge pclk);
        conv_valid <= 1'b1;
        conv_chan <= c;
        conv_raw <= raw;
        @(posedge pclk);
        conv_valid <= 1'b0;
        #1;
        check("result_valid", 32'h1, result_valid);
        check("result_data", exp, result_data);
    endtask : conv

    initial begin
        {presetn, psel, penable, pwrite, conv_valid, offset_valid} = '0;
        {paddr, pwdata, conv_raw, meas_offset, dac_code} = '0;
        conv_chan = DAB_CH_INPUT0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (addrs[i]) rd("reset value", addrs[i], 16'h0000);
        $display("test reset done");
        apb(1'b0, 8'h90, 32'h0);
        check("unmapped err", 32'h1, e);
        check("unmapped data", 32'h0, d);
        apb(1'b0, 8'h95, 32'h0);
        check("misaligned err", 32'h1, e);
        check("misaligned data", 32'h0, d);
        apb(1'b1, 8'h94, 32'h0000_0abc);
        rd("read only", 8'h94, 16'h0000);
        apb(1'b1, 8'hb8, 32'h0000_ffff);
        rd("override", 8'hb8, 16'hefff);
        check("gnd disable", 32'h1, ground_sampling_disable);
        apb(1'b1, 8'hb8, 32'h0);
        // the write lands at the access edge itself, so look one edge later
        @(posedge pclk);
        check("gnd enable", 32'h0, ground_sampling_disable);
        $display("test registers done");
        @(posedge pclk);
        offset_valid <= 1'b1;
        meas_offset <= 12'h005;
        @(posedge pclk);
        offset_valid <= 1'b0;
        rd("offset", 8'ha0, 16'h0005);
        conv(DAB_CH_INPUT1, 12'h100, 12'h0fb);
        rd("input1", 8'h94, 16'h00fb);
        rd("raw", 8'hb4, 16'h0100);
        conv(DAB_CH_TEMP, 12'h020, 12'h01b);
        rd("temp", 8'h98, 16'h001b);
        conv(DAB_CH_INPUT0, 12'h200, 12'h1fb);
        rd("input1 kept", 8'h94, 16'h00fb);
        conv(DAB_CH_DIAG, 12'h003, 12'h000);
        check("applied offset", 32'h5, applied_offset);
        $display("test correction done");
        apb(1'b1, 8'hb8, 32'h0000_4ffe);
        conv(DAB_CH_DIAG, 12'h010, 12'h012);
        check("offset override", 32'hffe, applied_offset);
        rd("diag", 8'h9c, 16'h0012);
        rd("offset kept", 8'ha0, 16'h0005);
        apb(1'b1, 8'hb8, 32'h0000_c123);
        conv(DAB_CH_TEMP, 12'h555, 12'h123);
        check("offset both set", 32'h5, applied_offset);
        rd("temp bypass", 8'h98, 16'h0123);
        rd("raw kept", 8'hb4, 16'h0555);
        $display("test override done");
        dac_code <= 16'hbeef;
        rd("dac code", 8'hb0, 16'hbeef);
        $display("test dac done");
        summarize();
    end
endmodule : test_dab_top
`default_nettype wire
